// ===== test/fwp_flash_model.sv
// two-die flash status model
`timescale 1ns/1ps
module fwp_flash_model (
    input wire logic sel_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic [31:0] wdata_i,
    input wire logic [1:0] busy_i,
    input wire logic [1:0] tl_i,
    input wire logic [1:0] susp_i,
    input wire logic sect_i,
    output logic [31:0] data_o,
    output logic rb_lower_o,
    output logic rb_upper_o,
    output int resets_o
);
    // what a sector outside the suspended erase holds
    localparam logic [31:0] ARRAY_WORD = 32'h0012_0034;
    logic [1:0] tog_reg = 2'h0;
    logic [1:0] tog2_reg = 2'h0;
    logic [31:0] last_reg = 32'h0;
    logic [31:0] word;
    int resets_reg = 0;
    assign resets_o = resets_reg;
    // busy_i stands for any embedded run: short protected-sector toggling,
    // partly protected erase and suspend-program alike
    // open drain with pull-up: released reads high
    assign rb_lower_o = !busy_i[0];
    assign rb_upper_o = !busy_i[1];
    always_comb begin
        word = 32'h0;
        for (int d = 0; d < 2; d++) begin
            word[16*d+7] = !busy_i[d] || susp_i[d];
            word[16*d+6] = tog_reg[d];
            word[16*d+5] = tl_i[d] && !susp_i[d];
            word[16*d+2] = susp_i[d] ? tog2_reg[d] : tog_reg[d];
        end
        if (|susp_i && !sect_i) begin
            word = ARRAY_WORD;
        end
    end
    // released bus shows the inverse of the last word, never a stale copy
    assign data_o = (!sel_n_i && !oe_n_i) ? word : ~last_reg;
    always @(posedge oe_n_i) begin
        if (!sel_n_i) begin
            last_reg <= word;
            tog_reg <= tog_reg ^ busy_i;
            tog2_reg <= tog2_reg ^ (susp_i & {2{sect_i}});
        end
    end
    always @(posedge we_n_i) begin
        if (!sel_n_i && wdata_i[7:0] == fwp_pkg::RESET_CMD) begin
            resets_reg <= resets_reg + 1;
        end
    end
endmodule : fwp_flash_model

// ===== test/fwp_poll_ctrl_monitor.sv
// port checks for the flash status poll controller
`timescale 1ns/1ps
module fwp_poll_ctrl_monitor #(
    parameter int ADDR_W = 21
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic sw_rd_i,
    input wire logic [31:0] sw_rdata_o,
    input wire logic flash_select_n_o,
    input wire logic flash_output_strobe_n_o,
    input wire logic flash_write_strobe_n_o,
    input wire logic [31:0] flash_data_o,
    input wire logic flash_data_oe_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    a_read_selected: assert property (!flash_output_strobe_n_o |-> !flash_select_n_o)
        else $error("output strobe without select");
    a_strobes_apart: assert property (flash_output_strobe_n_o || flash_write_strobe_n_o)
        else $error("read and write strobes together");
    a_write_drives: assert property (!flash_write_strobe_n_o |-> flash_data_oe_o && !flash_select_n_o)
        else $error("write strobe without bus drive");
    a_reset_byte: assert property (!flash_write_strobe_n_o |->
        flash_data_o[7:0] == fwp_pkg::RESET_CMD
        && flash_data_o[23:16] == fwp_pkg::RESET_CMD)
        else $error("reset command byte wrong");
    a_read_hold: assert property ($fell(flash_output_strobe_n_o) |=>
        !flash_output_strobe_n_o [*8])
        else $error("read strobe too short");
    a_read_gap: assert property ($rose(flash_output_strobe_n_o) |->
        flash_output_strobe_n_o [*3])
        else $error("read gap too short");
    a_write_width: assert property ($fell(flash_write_strobe_n_o) |->
        !flash_write_strobe_n_o [*5])
        else $error("write strobe width wrong");
    a_rdata_quiet: assert property (!$past(sw_rd_i) |-> sw_rdata_o == 32'h0)
        else $error("read data outside read slot");
endmodule : fwp_poll_ctrl_monitor
bind fwp_poll_ctrl fwp_poll_ctrl_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);

// ===== test/fwp_poll_ctrl_tb.sv
// self-checking bench for the flash status poll controller
`timescale 1ns/1ps
module fwp_poll_ctrl_tb;
    logic core_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] sw_addr_i = 4'h0;
    logic [31:0] sw_wdata_i = 32'h0;
    logic sw_wr_i = 1'b0;
    logic sw_rd_i = 1'b0;
    logic [1:0] busy = 2'h0;
    logic [1:0] tl = 2'h0;
    logic [1:0] susp = 2'h0;
    logic [31:0] sw_rdata_o, fl_out, fl_in, st;
    logic sel_n, oe_n, we_n, doe, rb_lo, rb_up;
    logic [20:0] faddr;
    int resets, failures = 0, n_compared = 0;
    always #5 core_clk_i = ~core_clk_i;
    fwp_poll_ctrl #(.PROG_LIMIT(32'd400), .ERASE_LIMIT(32'd2000)) dut (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .sw_addr_i(sw_addr_i),
        .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i),
        .sw_rdata_o(sw_rdata_o), .flash_select_n_o(sel_n),
        .flash_output_strobe_n_o(oe_n), .flash_write_strobe_n_o(we_n),
        .flash_addr_o(faddr), .flash_data_o(fl_out), .flash_data_oe_o(doe),
        .flash_data_i(fl_in), .ready_busy_n_lower_i(rb_lo), .ready_busy_n_upper_i(rb_up));
    fwp_flash_model u_flash (.sel_n_i(sel_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .wdata_i(fl_out), .busy_i(busy), .tl_i(tl), .susp_i(susp), .sect_i(faddr[20]),
        .data_o(fl_in),
        .rb_lower_o(rb_lo), .rb_upper_o(rb_up), .resets_o(resets));
    task automatic finish_test();
        if (failures == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        sw_addr_i <= a;
        sw_wdata_i <= d;
        sw_wr_i <= 1'b1;
        @(posedge core_clk_i);
        sw_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk_i);
        sw_addr_i <= a;
        sw_rd_i <= 1'b1;
        @(posedge core_clk_i);
        sw_rd_i <= 1'b0;
        #1 d = sw_rdata_o;
    endtask : rd
    // bounded wait for the poll to finish, leaves STATUS in st
    task automatic run_poll(input logic [31:0] ctrl);
        wr(fwp_pkg::REG_CTRL, ctrl);
        for (int i = 0; i < 3000; i++) begin
            rd(fwp_pkg::REG_STATUS, st);
            if (st[fwp_pkg::ST_BUSY] === 1'b0) return;
        end
        failures++;
        finish_test();
    endtask : run_poll
    task automatic t_regs();
        logic [31:0] d;
        rd(fwp_pkg::REG_STATUS, d);
        chk(d, 32'hc0);
        rd(fwp_pkg::REG_CTRL, d);
        chk(d, 32'h0);
        rd(4'h2, d);
        chk(d, 32'h0);
        wr(fwp_pkg::REG_ADDR, 32'h1234);
        rd(fwp_pkg::REG_ADDR, d);
        chk(d, 32'h1234);
        chk({11'h0, faddr}, 32'h1234);
    endtask : t_regs
    task automatic t_idle_done();
        logic [31:0] d;
        run_poll(32'h1);
        chk(st[4:1], 4'h3);
        rd(fwp_pkg::REG_LAST, d);
        chk(d, 32'h0080_0080);
    endtask : t_idle_done
    task automatic t_busy_then_done();
        busy <= 2'h1;
        wr(fwp_pkg::REG_CTRL, 32'h1);
        repeat (120) @(posedge core_clk_i);
        busy <= 2'h0;
        run_poll(32'h0);
        chk(st[5:1], 5'h03);
        chk(st[7:6], 2'h3);
    endtask : t_busy_then_done
    task automatic t_fail_reset();
        int r0;
        r0 = resets;
        busy <= 2'h2;
        tl <= 2'h2;
        run_poll(32'h1);
        chk(st[4:3], 2'h2);
        chk(resets - r0, 1);
        busy <= 2'h0;
        tl <= 2'h0;
        run_poll(32'h8);
        chk(resets - r0, 2);
    endtask : t_fail_reset
    task automatic t_timeout();
        int r0;
        r0 = resets;
        busy <= 2'h1;
        run_poll(32'h1);
        chk(st[5], 1'b1);
        chk(st[4:3], 2'h0);
        chk(resets - r0, 0);
        busy <= 2'h0;
    endtask : t_timeout
    // erase runs past the program limit and stops at its own
    task automatic t_erase_limit();
        busy <= 2'h1;
        wr(fwp_pkg::REG_CTRL, 32'h3);
        repeat (600) @(posedge core_clk_i);
        rd(fwp_pkg::REG_STATUS, st);
        chk(st[5:0], 6'h05);
        run_poll(32'h0);
        chk(st[5], 1'b1);
        busy <= 2'h0;
    endtask : t_erase_limit
    // abort late in the first strobe, then a fresh start
    task automatic t_abort_restart();
        busy <= 2'h1;
        wr(fwp_pkg::REG_CTRL, 32'h1);
        repeat (10) @(posedge core_clk_i);
        wr(fwp_pkg::REG_CTRL, 32'h4);
        rd(fwp_pkg::REG_STATUS, st);
        chk(st[5:0], 6'h00);
        chk(sel_n, 1'b1);
        busy <= 2'h0;
        run_poll(32'h1);
        chk(st[5:0], 6'h06);
    endtask : t_abort_restart
    // suspended sector gives the status pattern, other sectors array data
    task automatic t_suspend();
        logic [31:0] d;
        susp <= 2'h3;
        wr(fwp_pkg::REG_ADDR, 32'h0010_0000);
        run_poll(32'h1);
        chk(st[7:1], 7'h63);
        rd(fwp_pkg::REG_LAST, d);
        chk(d & 32'h00a4_00a4, 32'h0084_0084);
        wr(fwp_pkg::REG_ADDR, 32'h0);
        run_poll(32'h1);
        rd(fwp_pkg::REG_LAST, d);
        chk(d, 32'h0012_0034);
        susp <= 2'h0;
    endtask : t_suspend
    initial begin
        repeat (4) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        repeat (8) @(posedge core_clk_i);
        t_regs();
        t_idle_done();
        t_busy_then_done();
        t_fail_reset();
        t_timeout();
        t_erase_limit();
        t_abort_restart();
        t_suspend();
        finish_test();
    end
endmodule : fwp_poll_ctrl_tb

// ===== verilog/fwp_pkg.sv
// constants shared by the flash status poll controller
package fwp_pkg;
    // clock
    localparam int CLK_PERIOD_NS = 10;
    // flash bus timing, as printed
    localparam int T_ACC_NS = 100;
    localparam int T_WP_NS = 50;
    localparam int T_WPH_NS = 30;
    localparam int T_DF_NS = 30;
    localparam int SYNC_LAT_CYC = 3;
    localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WPH_CYC = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC = (T_DF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // hold the output strobe through access time plus input synchroniser
    localparam int RD_HOLD_CYC = ACC_CYC + SYNC_LAT_CYC + 1;
    // longest embedded operation times
    localparam int PROG_MAX_US = 300;
    localparam int ERASE_MAX_S = 15;
    localparam longint PROG_MAX_CYC = (64'(PROG_MAX_US) * 64'd1000) / 64'(CLK_PERIOD_NS);
    localparam longint ERASE_MAX_CYC =
        (64'(ERASE_MAX_S) * 64'd1000000000) / 64'(CLK_PERIOD_NS);
    // status word layout: two dies, one byte lane each
    localparam int DIES = 2;
    localparam int LANE_STRIDE = 16;
    localparam int TOG1_BIT = 6;
    localparam int TOG2_BIT = 2;
    localparam int TL_BIT = 5;
    localparam int POLL_BIT = 7;
    // reset command byte, placed in each die's low lane
    localparam logic [7:0] RESET_CMD = 8'hf0;
    // software register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_ADDR = 4'h8;
    localparam logic [3:0] REG_LAST = 4'hc;
    // control bits
    localparam int CTRL_START = 0;
    localparam int CTRL_ERASE = 1;
    localparam int CTRL_ABORT = 2;
    localparam int CTRL_RESET = 3;
    // status bits
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_FAIL = 3;
    localparam int ST_TIMEOUT = 5;
    localparam int ST_RDY = 6;
    // controller states, gray along idle-read-eval-write
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_READ = 2'h1,
        ST_EVAL = 2'h3,
        ST_WRITE = 2'h2
    } fwp_state_t;
endpackage : fwp_pkg

// ===== verilog/fwp_poll_ctrl.sv
// host controller that polls two flash dies for program/erase status
// How it works
// R01 - device pulls ready/busy low while busy
// R02 - ready/busy is open drain, valid after command
// R03 - toggle one flips each read while busy
// R04 - toggle one readable at any address
// R05 - all-protected erase toggles about 100 us
// R06 - protected sectors skipped during erase
// R07 - protected program address toggles about 1 us
// R08 - toggle one halts in erase suspend
// R09 - toggle one flips during suspend program
// R10 - toggle two flips inside erase-selected sectors
// R11 - host paces status reads with output strobe
// R12 - suspended sector reads fixed status pattern
// R13 - other sectors read array data in suspend
// R14 - time-limit bit set when limit exceeded
// R15 - programming one over zero ends in failure
// R16 - host sends reset command after failure
// R17 - host reads twice, compares toggle bit
// R18 - toggling with time-limit high: recheck, then reset
// R19 - host restarts with double read after leaving
// R20 - program 300 us, erase 15 s at most
// R21 - poll bit complements programmed value while busy
// R22 - poll bit zero during erase, one after
// R23 - each die reports on its own lane
`timescale 1ns/1ps
module fwp_poll_ctrl #(
    parameter int ADDR_W = 21,
    parameter logic [31:0] PROG_LIMIT = 32'(fwp_pkg::PROG_MAX_CYC),
    parameter logic [31:0] ERASE_LIMIT = 32'(fwp_pkg::ERASE_MAX_CYC)
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] sw_addr_i,
    input wire logic [31:0] sw_wdata_i,
    input wire logic sw_wr_i,
    input wire logic sw_rd_i,
    output logic [31:0] sw_rdata_o,
    output logic flash_select_n_o,
    output logic flash_output_strobe_n_o,
    output logic flash_write_strobe_n_o,
    output logic [ADDR_W-1:0] flash_addr_o,
    output logic [31:0] flash_data_o,
    output logic flash_data_oe_o,
    input wire logic [31:0] flash_data_i,
    input wire logic ready_busy_n_lower_i,
    input wire logic ready_busy_n_upper_i
);
    typedef struct packed {
        fwp_pkg::fwp_state_t st;
        logic [7:0] cnt;
        logic gap;
        logic first;
        logic [31:0] prev;
        logic [31:0] cur;
        logic [31:0] tmo;
        logic erase;
        logic [1:0] done;
        logic [1:0] fail;
        logic [1:0] recheck;
        logic timeout;
        logic busy;
        logic [31:0] rdata;
        logic sel_n;
        logic oe_n;
        logic we_n;
        logic data_oe;
        logic [31:0] wdata;
        logic [ADDR_W-1:0] addr;
    } fwp_st_t;

    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [31:0] data_s;
    logic [1:0] rb_s;
    fwp_st_t r_reg;
    fwp_st_t r_next;

    // picks one status bit of one die's byte lane
    function automatic logic lane_bit(input logic [31:0] w, input int die, input int b);
        lane_bit = w[die * fwp_pkg::LANE_STRIDE + b];
    endfunction : lane_bit

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // data bus sampled through the synchroniser; strobe held long enough to settle
    fwp_sync #(.W(32)) u_data_sync (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .d_i(flash_data_i),
        .q_o(data_s)
    );

    fwp_sync #(.W(2)) u_rb_sync (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .d_i({ready_busy_n_upper_i, ready_busy_n_lower_i}), // [R02] [R23]
        .q_o(rb_s)
    );

    always_comb begin
        logic tg;
        logic [31:0] limit;
        tg = 1'b0;
        limit = r_reg.erase ? ERASE_LIMIT : PROG_LIMIT; // [R20]
        r_next = r_reg;
        r_next.rdata = 32'h0;

        // software read port, data valid one cycle after the strobe
        if (sw_rd_i) begin
            case (sw_addr_i)
                fwp_pkg::REG_STATUS: begin
                    r_next.rdata[fwp_pkg::ST_BUSY] = r_reg.busy;
                    r_next.rdata[fwp_pkg::ST_DONE +: 2] = r_reg.done;
                    r_next.rdata[fwp_pkg::ST_FAIL +: 2] = r_reg.fail;
                    r_next.rdata[fwp_pkg::ST_TIMEOUT] = r_reg.timeout;
                    r_next.rdata[fwp_pkg::ST_RDY +: 2] = rb_s; // [R01]
                end
                fwp_pkg::REG_ADDR: r_next.rdata[ADDR_W-1:0] = r_reg.addr;
                fwp_pkg::REG_LAST: r_next.rdata = r_reg.cur; // [R21] [R22]
                default: r_next.rdata = 32'h0;
            endcase
        end

        case (r_reg.st)
            fwp_pkg::ST_IDLE: begin
                if (sw_wr_i && sw_addr_i == fwp_pkg::REG_ADDR) begin
                    r_next.addr = sw_wdata_i[ADDR_W-1:0]; // [R10]
                end
                if (sw_wr_i && sw_addr_i == fwp_pkg::REG_CTRL) begin
                    if (sw_wdata_i[fwp_pkg::CTRL_START]) begin
                        // every start begins with a fresh read pair
                        r_next.st = fwp_pkg::ST_READ; // [R19]
                        r_next.first = 1'b1; // [R17]
                        r_next.erase = sw_wdata_i[fwp_pkg::CTRL_ERASE];
                        r_next.done = 2'h0;
                        r_next.fail = 2'h0;
                        r_next.recheck = 2'h0;
                        r_next.timeout = 1'b0;
                        r_next.tmo = 32'h0;
                        r_next.busy = 1'b1;
                        r_next.cnt = 8'h0;
                        r_next.gap = 1'b0;
                        r_next.sel_n = 1'b0;
                        r_next.oe_n = 1'b0; // [R11]
                    end else if (sw_wdata_i[fwp_pkg::CTRL_RESET]) begin
                        r_next.st = fwp_pkg::ST_WRITE;
                        r_next.busy = 1'b1;
                        r_next.cnt = 8'h0;
                        r_next.gap = 1'b0;
                        r_next.sel_n = 1'b0;
                        r_next.we_n = 1'b0;
                        r_next.data_oe = 1'b1;
                    end
                end
            end
            fwp_pkg::ST_READ: begin
                r_next.tmo = r_reg.tmo + 32'h1;
                r_next.cnt = r_reg.cnt + 8'h1;
                if (!r_reg.gap && r_reg.cnt == 8'(fwp_pkg::RD_HOLD_CYC - 1)) begin
                    // each output strobe is one read cycle to the flash
                    r_next.cur = data_s; // [R03] [R04]
                    r_next.oe_n = 1'b1;
                    r_next.gap = 1'b1;
                    r_next.cnt = 8'h0;
                end else if (r_reg.gap && r_reg.cnt == 8'(fwp_pkg::GAP_CYC - 1)) begin
                    r_next.cnt = 8'h0;
                    r_next.gap = 1'b0;
                    if (r_reg.first) begin
                        r_next.first = 1'b0;
                        r_next.prev = r_reg.cur;
                        r_next.oe_n = 1'b0; // [R17]
                    end else begin
                        r_next.st = fwp_pkg::ST_EVAL;
                    end
                end
                if (sw_wr_i && sw_addr_i == fwp_pkg::REG_CTRL
                        && sw_wdata_i[fwp_pkg::CTRL_ABORT]) begin
                    // leaving mid-poll loses the pair; a later start rereads twice
                    r_next.st = fwp_pkg::ST_IDLE; // [R19]
                    r_next.busy = 1'b0;
                    r_next.oe_n = 1'b1;
                    r_next.sel_n = 1'b1;
                end else if (r_reg.tmo >= limit) begin
                    r_next.st = fwp_pkg::ST_IDLE; // [R20]
                    r_next.timeout = 1'b1;
                    r_next.busy = 1'b0;
                    r_next.oe_n = 1'b1;
                    r_next.sel_n = 1'b1;
                end
            end
            fwp_pkg::ST_EVAL: begin
                for (int d = 0; d < fwp_pkg::DIES; d++) begin // [R23]
                    tg = lane_bit(r_reg.cur, d, fwp_pkg::TOG1_BIT)
                        ^ lane_bit(r_reg.prev, d, fwp_pkg::TOG1_BIT);
                    if (!r_reg.done[d] && !r_reg.fail[d]) begin
                        if (!tg) begin
                            r_next.done[d] = 1'b1; // [R17] [R08]
                        end else if (r_reg.recheck[d]) begin
                            r_next.fail[d] = 1'b1; // [R18]
                        end else if (lane_bit(r_reg.cur, d, fwp_pkg::TL_BIT)) begin
                            r_next.recheck[d] = 1'b1; // [R14] [R18]
                        end
                    end
                end
                if (&(r_next.done | r_next.fail)) begin
                    r_next.oe_n = 1'b1;
                    r_next.cnt = 8'h0;
                    if (|r_next.fail) begin
                        // a failed die stays in status output until reset
                        r_next.st = fwp_pkg::ST_WRITE; // [R16]
                        r_next.we_n = 1'b0;
                        r_next.data_oe = 1'b1;
                        r_next.gap = 1'b0;
                    end else begin
                        r_next.st = fwp_pkg::ST_IDLE;
                        r_next.busy = 1'b0;
                        r_next.sel_n = 1'b1;
                    end
                end else begin
                    // one more read, compared with the last one
                    r_next.st = fwp_pkg::ST_READ; // [R18]
                    r_next.prev = r_reg.cur;
                    r_next.oe_n = 1'b0;
                    r_next.cnt = 8'h0;
                    r_next.gap = 1'b0;
                end
            end
            fwp_pkg::ST_WRITE: begin
                r_next.cnt = r_reg.cnt + 8'h1;
                if (!r_reg.gap && r_reg.cnt == 8'(fwp_pkg::WP_CYC - 1)) begin
                    r_next.we_n = 1'b1; // [R16]
                    r_next.gap = 1'b1;
                    r_next.cnt = 8'h0;
                end else if (r_reg.gap && r_reg.cnt == 8'(fwp_pkg::WPH_CYC - 1)) begin
                    r_next.st = fwp_pkg::ST_IDLE;
                    r_next.gap = 1'b0;
                    r_next.cnt = 8'h0;
                    r_next.data_oe = 1'b0;
                    r_next.sel_n = 1'b1;
                    r_next.busy = 1'b0;
                end
            end
            default: r_next.st = fwp_pkg::ST_IDLE;
        endcase
        // command word set with the strobe edge, so the first low cycle already carries it
        r_next.wdata = r_next.data_oe ? {8'h00, fwp_pkg::RESET_CMD, 8'h00, fwp_pkg::RESET_CMD}
            : 32'h0; // [R16]
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '{st: fwp_pkg::ST_IDLE, sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign sw_rdata_o = r_reg.rdata;
    assign flash_select_n_o = r_reg.sel_n;
    assign flash_output_strobe_n_o = r_reg.oe_n;
    assign flash_write_strobe_n_o = r_reg.we_n;
    assign flash_addr_o = r_reg.addr;
    assign flash_data_o = r_reg.wdata;
    assign flash_data_oe_o = r_reg.data_oe;
endmodule : fwp_poll_ctrl

// ===== verilog/fwp_sync.sv
// three-stage pin input synchroniser, output moves when stages two and three agree
`timescale 1ns/1ps
module fwp_sync #(
    parameter int W = 1
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } fwp_sync_st_t;

    fwp_sync_st_t r_reg;
    fwp_sync_st_t r_next;

    always_comb begin
        r_next = r_reg;
        r_next.s1 = d_i;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        for (int i = 0; i < W; i++) begin
            if (r_reg.s2[i] == r_reg.s3[i]) begin
                r_next.q[i] = r_reg.s3[i];
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign q_o = r_reg.q;
endmodule : fwp_sync
